/* spc_defs.svh */
// Constants for the serdes physical-layer reset and channel PLL configuration block.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// Reconfiguration port word addresses
`define SPC_ADDR_W 9
`define SPC_ADDR_CFG_LOW 9'h05C
`define SPC_ADDR_CFG_HIGH 9'h05D
`define SPC_ADDR_DIV_SEL 9'h05E
`define SPC_ADDR_STATUS 9'h05F
`define SPC_ADDR_CTRL 9'h060

// Field positions in the divider word and the config low word
`define SPC_DIV_M_HI 12
`define SPC_DIV_M_LO 8
`define SPC_DIV_N1_BIT 7
`define SPC_DIV_N2_HI 6
`define SPC_DIV_N2_LO 0
`define SPC_CFG_LOW_HI 15
`define SPC_CFG_LOW_LO 8

// Divider field encodings
`define SPC_ENC_M1 5'h10
`define SPC_ENC_M2 5'h00
`define SPC_ENC_N2_1 7'h10
`define SPC_ENC_N2_2 7'h00
`define SPC_ENC_N2_3 7'h01
`define SPC_ENC_N2_4 7'h02
`define SPC_ENC_N2_5 7'h03

// Reset values of the configuration words
`define SPC_RST_CFG_LOW 8'h00
`define SPC_RST_CFG_HIGH 16'h0000
`define SPC_RST_DIV_SEL 13'h1082
`define SPC_RST_CTRL 5'h00

// Datapath and user clock ratios
`define SPC_RATIO_32B 7'd40
`define SPC_RATIO_64B 7'd66
`define SPC_USR_RATIO_HP 7'd33
`define SPC_USR_RATIO_TOP 7'd66

// Reset sequence hold counts in reconfiguration clock cycles
`define SPC_PLL_HOLD_CYCLES 16
`define SPC_DP_HOLD_CYCLES 8

// Management address bit that selects the shared quad PLL space
`define SPC_MGMT_COMMON_BIT 9

`endif

/* spc_pkg.sv */
// Types shared by the serdes physical-layer configuration block.
// Assumes spc_defs.svh is on the include path.
`default_nettype none
package spc_pkg;
  `include "spc_defs.svh"

  typedef enum logic [2:0] {
    SEQ_PLL_RST = 3'b000,
    SEQ_PLL_LOCK = 3'b001,
    SEQ_DP_RST = 3'b010,
    SEQ_DP_WAIT = 3'b011,
    SEQ_DONE = 3'b100
  } spc_seq_state_t;

  typedef enum logic [1:0] {
    MGT_IDLE = 2'b00,
    MGT_LOCAL = 2'b01,
    MGT_COMMON = 2'b10,
    MGT_ACK = 2'b11
  } spc_mgmt_state_t;

  typedef enum logic [1:0] {
    XCVR_LOW_END = 2'b00,
    XCVR_HIGH_PERF = 2'b01,
    XCVR_TOP_RATE = 2'b10
  } spc_xcvr_type_t;
endpackage : spc_pkg
`default_nettype wire

/* spc_reset_seq.sv */
// One reset sequencer for either the transmit or the receive direction.
// Assumes its reset and status inputs are already synchronised to clk.
`default_nettype none
module spc_reset_seq
  import spc_pkg::*;
#(
  parameter int PLL_HOLD = `SPC_PLL_HOLD_CYCLES,
  parameter int DP_HOLD = `SPC_DP_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests
  input wire logic sys_reset,
  input wire logic dp_reset,
  // Transceiver status
  input wire logic pll_lock,
  input wire logic xcvr_done,
  // Controls and flag
  output logic pll_reset,
  output logic datapath_reset,
  output logic reset_done
);
  localparam int CW = $clog2(PLL_HOLD + DP_HOLD + 1);
  localparam logic [CW-1:0] PLL_LOAD = CW'(PLL_HOLD - 1);
  localparam logic [CW-1:0] DP_LOAD = CW'(DP_HOLD - 1);

  spc_seq_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  wire logic cnt_zero = (cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - CW'(1);
    if (sys_reset) begin
      state_next = SEQ_PLL_RST;
      cnt_next = PLL_LOAD;
    end else if (dp_reset && state_reg != SEQ_PLL_RST && state_reg != SEQ_PLL_LOCK) begin
      state_next = SEQ_DP_RST;
      cnt_next = DP_LOAD;
    end else begin
      case (state_reg)
        SEQ_PLL_RST: if (cnt_zero) state_next = SEQ_PLL_LOCK;
        SEQ_PLL_LOCK: begin
          if (pll_lock) begin
            state_next = SEQ_DP_RST;
            cnt_next = DP_LOAD;
          end
        end
        SEQ_DP_RST: if (cnt_zero) state_next = SEQ_DP_WAIT;
        SEQ_DP_WAIT: if (xcvr_done) state_next = SEQ_DONE;
        SEQ_DONE: state_next = SEQ_DONE;
        default: state_next = SEQ_PLL_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_PLL_RST;
      cnt_reg <= PLL_LOAD;
      pll_reset <= 1'b1;
      datapath_reset <= 1'b1;
      reset_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pll_reset <= (state_next == SEQ_PLL_RST);
      datapath_reset <= (state_next != SEQ_DP_WAIT) && (state_next != SEQ_DONE);
      reset_done <= (state_next == SEQ_DONE);
    end
  end
endmodule : spc_reset_seq
`default_nettype wire

/* spc_phy_top.sv */
// Serdes physical-layer wrapper: reconfiguration registers, management bridge, resets.
// Assumes core_clk is the auxiliary reconfiguration clock and the transceiver sits outside.
`default_nettype none
module spc_phy_top
  import spc_pkg::*;
#(
  parameter bit MGMT_EN = 1'b1,
  parameter bit SHARED_QUAD_PLL = 1'b1,
  parameter bit DEBUG_EN = 1'b1,
  parameter bit QUAD_PLL_SELECTED = 1'b0,
  parameter bit QUAD_PLL_SEL_INDEX = 1'b0,
  parameter bit DATAPATH_64 = 1'b0,
  parameter spc_xcvr_type_t XCVR_TYPE = XCVR_HIGH_PERF,
  parameter int PLL_HOLD = `SPC_PLL_HOLD_CYCLES,
  parameter int DP_HOLD = `SPC_DP_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Reconfiguration port
  input wire logic drp_en,
  input wire logic drp_we,
  input wire logic [`SPC_ADDR_W-1:0] drp_addr,
  input wire logic [15:0] drp_di,
  output logic [15:0] drp_do,
  output logic drp_rdy,
  // Management bridge, sender's clock domain
  input wire logic mgmt_req_tgl,
  input wire logic mgmt_we,
  input wire logic [`SPC_MGMT_COMMON_BIT:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic mgmt_ack_tgl,
  output logic [15:0] mgmt_rdata,
  // Internal shared quad PLL reconfiguration
  output logic common_reconfig_en,
  output logic common_reconfig_we,
  output logic [`SPC_ADDR_W-1:0] common_reconfig_addr,
  output logic [15:0] common_reconfig_di,
  input wire logic [15:0] common_reconfig_do,
  input wire logic common_reconfig_rdy,
  // Link layer resets, asynchronous
  input wire logic tx_sys_reset,
  input wire logic transmit_datapath_reset,
  input wire logic rx_sys_reset,
  input wire logic receive_datapath_reset,
  output logic tx_reset_done,
  output logic rx_reset_done,
  // Transceiver reset controls and status
  input wire logic tx_pll_lock,
  input wire logic rx_pll_lock,
  input wire logic tx_xcvr_done,
  input wire logic rx_xcvr_done,
  output logic tx_pll_reset,
  output logic rx_pll_reset,
  output logic tx_dp_reset,
  output logic rx_dp_reset,
  // Channel PLL settings
  output logic [23:0] channel_pll_config,
  output logic [2:0] channel_pll_ref_divider,
  output logic [2:0] channel_pll_fb_div_n1,
  output logic [2:0] channel_pll_fb_div_n2,
  output logic channel_pll_div_invalid,
  // Debug controls
  input wire logic [2:0] dbg_loopback,
  input wire logic dbg_tx_polarity,
  input wire logic dbg_rx_polarity,
  output logic [2:0] xcvr_loopback,
  output logic xcvr_tx_polarity,
  output logic xcvr_rx_polarity,
  // Clocking and reference selection
  output logic [6:0] core_clk_ratio,
  output logic [6:0] usr_clk_ratio,
  output logic core_clk_via_buffer,
  output logic [3:0] bytes_per_cycle,
  output logic [1:0] refclk_used
);
  // Reset release through two flops
  logic rst_meta_reg, rst_n_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Three-flop input filter: a bit sets once stages two and three are both high and clears once they differ
  localparam int NS = 9;
  wire logic [NS-1:0] async_in = {mgmt_req_tgl, rx_xcvr_done, tx_xcvr_done, rx_pll_lock,
    tx_pll_lock, receive_datapath_reset, rx_sys_reset, transmit_datapath_reset, tx_sys_reset};
  logic [NS-1:0] s1_reg, s2_reg, s3_reg, sync_reg;
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_reg <= (s2_reg & s3_reg) | (sync_reg & ~(s2_reg ^ s3_reg));
    end
  end

  // Configuration registers
  logic [7:0] cfg_low_reg;
  logic [15:0] cfg_high_reg;
  logic [12:0] div_sel_reg;
  logic [4:0] ctrl_reg;

  function automatic logic [15:0] read_word(input logic [`SPC_ADDR_W-1:0] a,
      input logic [15:0] status);
    case (a)
      `SPC_ADDR_CFG_LOW: read_word = {cfg_low_reg, 8'h00};
      `SPC_ADDR_CFG_HIGH: read_word = cfg_high_reg;
      `SPC_ADDR_DIV_SEL: read_word = {3'h0, div_sel_reg};
      `SPC_ADDR_STATUS: read_word = status;
      `SPC_ADDR_CTRL: read_word = {11'h000, ctrl_reg};
      default: read_word = 16'h0000;
    endcase
  endfunction : read_word

  // Management request detection and state
  spc_mgmt_state_t mst_reg;
  logic req_seen_reg;
  logic [`SPC_MGMT_COMMON_BIT:0] m_addr_reg;
  logic m_we_reg;
  logic [15:0] m_wdata_reg;
  wire logic m_new = MGMT_EN && (sync_reg[8] != req_seen_reg) && (mst_reg == MGT_IDLE);
  wire logic m_common = m_addr_reg[`SPC_MGMT_COMMON_BIT];
  wire logic common_allowed = MGMT_EN && SHARED_QUAD_PLL && QUAD_PLL_SELECTED;
  // Port access has priority; a local management access waits until drp_en is low
  wire logic m_local_go = (mst_reg == MGT_LOCAL) && !drp_en;
  wire logic port_wr = drp_en && drp_we;
  wire logic m_wr = m_local_go && m_we_reg;
  wire logic any_wr = port_wr || m_wr;
  wire logic [`SPC_ADDR_W-1:0] wr_addr = port_wr ? drp_addr : m_addr_reg[`SPC_ADDR_W-1:0];
  wire logic [15:0] wr_data = port_wr ? drp_di : m_wdata_reg;

  // Divider decode
  wire logic [4:0] m_field = div_sel_reg[`SPC_DIV_M_HI:`SPC_DIV_M_LO];
  wire logic n1_field = div_sel_reg[`SPC_DIV_N1_BIT];
  wire logic [6:0] n2_field = div_sel_reg[`SPC_DIV_N2_HI:`SPC_DIV_N2_LO];
  wire logic m_ok = (m_field == `SPC_ENC_M1) || (m_field == `SPC_ENC_M2);
  wire logic n2_ok = (n2_field == `SPC_ENC_N2_1) || (n2_field <= `SPC_ENC_N2_5);
  wire logic [2:0] m_val = (m_field == `SPC_ENC_M1) ? 3'd1 : 3'd2;
  wire logic [2:0] n1_val = n1_field ? 3'd5 : 3'd4;
  wire logic [2:0] n2_val = (n2_field == `SPC_ENC_N2_1) ? 3'd1 :
    3'(n2_field[2:0] + 3'd2);

  wire logic [15:0] status_word = {tx_reset_done, rx_reset_done, sync_reg[3], sync_reg[4],
    channel_pll_div_invalid, 11'h000};

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_low_reg <= `SPC_RST_CFG_LOW;
      cfg_high_reg <= `SPC_RST_CFG_HIGH;
      div_sel_reg <= `SPC_RST_DIV_SEL;
      ctrl_reg <= `SPC_RST_CTRL;
    end else if (any_wr) begin
      case (wr_addr)
        `SPC_ADDR_CFG_LOW: cfg_low_reg <= wr_data[`SPC_CFG_LOW_HI:`SPC_CFG_LOW_LO];
        `SPC_ADDR_CFG_HIGH: cfg_high_reg <= wr_data;
        `SPC_ADDR_DIV_SEL: div_sel_reg <= wr_data[12:0];
        `SPC_ADDR_CTRL: ctrl_reg <= wr_data[4:0];
        default: ;
      endcase
    end
  end

  // Reconfiguration port answers one cycle after the enable
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      drp_rdy <= 1'b0;
      drp_do <= 16'h0000;
    end else begin
      drp_rdy <= drp_en;
      if (drp_en && !drp_we) drp_do <= read_word(drp_addr, status_word);
    end
  end

  // One enable per common access: tracked by a flag cleared on return to idle
  logic common_issued_reg;
  function automatic logic m_common_issued(input logic unused_sel);
    m_common_issued = common_issued_reg & unused_sel;
  endfunction : m_common_issued

  // Management bridge; sender holds its fields stable until the acknowledge toggles
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mst_reg <= MGT_IDLE;
      req_seen_reg <= 1'b0;
      m_addr_reg <= '0;
      m_we_reg <= 1'b0;
      m_wdata_reg <= 16'h0000;
      mgmt_ack_tgl <= 1'b0;
      mgmt_rdata <= 16'h0000;
      common_reconfig_en <= 1'b0;
      common_reconfig_we <= 1'b0;
      common_reconfig_addr <= '0;
      common_reconfig_di <= 16'h0000;
    end else begin
      common_reconfig_en <= 1'b0;
      case (mst_reg)
        MGT_IDLE: begin
          if (m_new) begin
            req_seen_reg <= sync_reg[8];
            m_addr_reg <= mgmt_addr;
            m_we_reg <= mgmt_we;
            m_wdata_reg <= mgmt_wdata;
            mst_reg <= mgmt_addr[`SPC_MGMT_COMMON_BIT] ? MGT_COMMON : MGT_LOCAL;
          end
        end
        MGT_LOCAL: begin
          if (m_local_go) begin
            if (!m_we_reg) mgmt_rdata <= read_word(m_addr_reg[`SPC_ADDR_W-1:0], status_word);
            mst_reg <= MGT_ACK;
          end
        end
        MGT_COMMON: begin
          if (!common_allowed) begin
            mgmt_rdata <= 16'h0000;
            mst_reg <= MGT_ACK;
          end else if (!common_reconfig_en && common_reconfig_rdy) begin
            if (!m_we_reg) mgmt_rdata <= common_reconfig_do;
            mst_reg <= MGT_ACK;
          end else if (!common_reconfig_en && !m_common_issued(m_common)) begin
            common_reconfig_en <= 1'b1;
          end
          common_reconfig_we <= m_we_reg;
          common_reconfig_addr <= m_addr_reg[`SPC_ADDR_W-1:0];
          common_reconfig_di <= m_wdata_reg;
        end
        MGT_ACK: begin
          mgmt_ack_tgl <= ~mgmt_ack_tgl;
          mst_reg <= MGT_IDLE;
        end
        default: mst_reg <= MGT_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) common_issued_reg <= 1'b0;
    else if (mst_reg != MGT_COMMON) common_issued_reg <= 1'b0;
    else if (common_reconfig_en) common_issued_reg <= 1'b1;
  end

  // Independent transmit and receive sequencers on the reconfiguration clock
  wire logic tx_pll_rst_w, tx_dp_rst_w, tx_done_w;
  wire logic rx_pll_rst_w, rx_dp_rst_w, rx_done_w;
  spc_reset_seq #(.PLL_HOLD(PLL_HOLD), .DP_HOLD(DP_HOLD)) u_tx_seq (
    .clk(core_clk),
    .rst_n(rst_n_reg),
    .sys_reset(sync_reg[0]),
    .dp_reset(sync_reg[1]),
    .pll_lock(sync_reg[4]),
    .xcvr_done(sync_reg[6]),
    .pll_reset(tx_pll_rst_w),
    .datapath_reset(tx_dp_rst_w),
    .reset_done(tx_done_w)
  );
  spc_reset_seq #(.PLL_HOLD(PLL_HOLD), .DP_HOLD(DP_HOLD)) u_rx_seq (
    .clk(core_clk),
    .rst_n(rst_n_reg),
    .sys_reset(sync_reg[2]),
    .dp_reset(sync_reg[3]),
    .pll_lock(sync_reg[5]),
    .xcvr_done(sync_reg[7]),
    .pll_reset(rx_pll_rst_w),
    .datapath_reset(rx_dp_rst_w),
    .reset_done(rx_done_w)
  );

  // Debug inputs lose the signals that registers own when the bus is built in
  wire logic [4:0] dbg_word = DEBUG_EN ? {dbg_rx_polarity, dbg_tx_polarity, dbg_loopback} : 5'h00;
  wire logic [4:0] ctrl_eff = MGMT_EN ? ctrl_reg : dbg_word;
  wire logic [1:0] refclk_sel = QUAD_PLL_SEL_INDEX ? 2'b10 : 2'b01;
  wire logic [1:0] refclk_w = (MGMT_EN && QUAD_PLL_SELECTED) ? 2'b11 : refclk_sel;
  wire logic [6:0] usr_ratio_w = (XCVR_TYPE == XCVR_TOP_RATE) ? `SPC_USR_RATIO_TOP :
    `SPC_USR_RATIO_HP;

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_pll_reset <= 1'b1;
      rx_pll_reset <= 1'b1;
      tx_dp_reset <= 1'b1;
      rx_dp_reset <= 1'b1;
      tx_reset_done <= 1'b0;
      rx_reset_done <= 1'b0;
      channel_pll_config <= 24'h000000;
      channel_pll_ref_divider <= 3'd1;
      channel_pll_fb_div_n1 <= 3'd4;
      channel_pll_fb_div_n2 <= 3'd1;
      channel_pll_div_invalid <= 1'b0;
      xcvr_loopback <= 3'h0;
      xcvr_tx_polarity <= 1'b0;
      xcvr_rx_polarity <= 1'b0;
      core_clk_ratio <= `SPC_RATIO_32B;
      usr_clk_ratio <= `SPC_USR_RATIO_HP;
      core_clk_via_buffer <= 1'b0;
      bytes_per_cycle <= 4'd4;
      refclk_used <= 2'b00;
    end else begin
      tx_pll_reset <= tx_pll_rst_w;
      rx_pll_reset <= rx_pll_rst_w;
      tx_dp_reset <= tx_dp_rst_w;
      rx_dp_reset <= rx_dp_rst_w;
      tx_reset_done <= tx_done_w && !sync_reg[0] && !sync_reg[1];
      rx_reset_done <= rx_done_w && !sync_reg[2] && !sync_reg[3];
      channel_pll_config <= {cfg_high_reg, cfg_low_reg};
      channel_pll_ref_divider <= m_val;
      channel_pll_fb_div_n1 <= n1_val;
      channel_pll_fb_div_n2 <= n2_val;
      channel_pll_div_invalid <= !(m_ok && n2_ok);
      xcvr_loopback <= ctrl_eff[2:0];
      xcvr_tx_polarity <= ctrl_eff[3];
      xcvr_rx_polarity <= ctrl_eff[4];
      core_clk_ratio <= DATAPATH_64 ? `SPC_RATIO_64B : `SPC_RATIO_32B;
      usr_clk_ratio <= usr_ratio_w;
      core_clk_via_buffer <= DATAPATH_64;
      bytes_per_cycle <= DATAPATH_64 ? 4'd8 : 4'd4;
      refclk_used <= refclk_w;
    end
  end
endmodule : spc_phy_top
`default_nettype wire

/* spc_phy_top_props.sv */
// Port checker for the serdes PHY wrapper.
// Assumes the 32-bit high-performance build with no quad PLL selected.
`default_nettype none
`include "spc_defs.svh"
module spc_phy_top_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic drp_en,
  input wire logic drp_we,
  input wire logic [`SPC_ADDR_W-1:0] drp_addr,
  input wire logic [15:0] drp_do,
  input wire logic drp_rdy,
  // Reset requests and results
  input wire logic tx_sys_reset,
  input wire logic transmit_datapath_reset,
  input wire logic rx_sys_reset,
  input wire logic receive_datapath_reset,
  input wire logic tx_reset_done,
  input wire logic rx_reset_done,
  input wire logic tx_xcvr_done,
  input wire logic tx_pll_reset,
  input wire logic rx_pll_reset,
  input wire logic tx_dp_reset,
  // Quad PLL port enable and clocking
  input wire logic common_reconfig_en,
  input wire logic [6:0] core_clk_ratio,
  input wire logic [6:0] usr_clk_ratio,
  input wire logic [3:0] bytes_per_cycle
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic rd_reg;
  logic [8:0] ra_reg;
  // Remembers what the answered access was
  always_ff @(posedge core_clk) begin
    rd_reg <= drp_en && !drp_we;
    ra_reg <= drp_addr;
  end
  a_rdy_one_cycle: assert property (drp_en |=> drp_rdy && !$past(drp_rdy))
    else $error("ready not one cycle after strobe");
  a_div_top_zero: assert property (drp_rdy && rd_reg && ra_reg == `SPC_ADDR_DIV_SEL
    |-> drp_do[15:13] == 3'h0) else $error("divider word top bits set");
  a_cfg_low_zero: assert property (drp_rdy && rd_reg && ra_reg == `SPC_ADDR_CFG_LOW
    |-> drp_do[7:0] == 8'h00) else $error("config low byte not zero");
  a_tx_sys_hold: assert property (tx_sys_reset [*8] |-> tx_pll_reset && !tx_reset_done)
    else $error("tx system reset not held");
  a_rx_sys_hold: assert property (rx_sys_reset [*8] |-> rx_pll_reset && !rx_reset_done)
    else $error("rx system reset not held");
  a_tx_dp_drive: assert property (transmit_datapath_reset [*8]
    |-> tx_dp_reset && !tx_reset_done) else $error("tx datapath reset not driven");
  a_tx_pll_kept: assert property ($rose(transmit_datapath_reset)
    && tx_reset_done && !tx_sys_reset |-> (!tx_pll_reset) [*8])
    else $error("tx pll reset by datapath reset");
  a_rx_pll_kept: assert property ($rose(receive_datapath_reset)
    && rx_reset_done && !rx_sys_reset |-> (!rx_pll_reset) [*8])
    else $error("rx pll reset by datapath reset");
  a_done_after_seq: assert property ($rose(tx_reset_done)
    |-> tx_xcvr_done && !tx_pll_reset && !tx_dp_reset) else $error("tx done early");
  a_no_quad_port: assert property (!common_reconfig_en)
    else $error("quad port used while not selected");
  a_ratio_fixed: assert property (core_clk_ratio == `SPC_RATIO_32B
    && bytes_per_cycle == 4'h4 && usr_clk_ratio == `SPC_USR_RATIO_HP)
    else $error("clock ratio wrong");
endmodule : spc_phy_top_props
bind spc_phy_top spc_phy_top_props u_props (.core_clk, .reset_n, .drp_en, .drp_we, .drp_addr,
  .drp_do, .drp_rdy, .tx_sys_reset, .transmit_datapath_reset, .rx_sys_reset,
  .receive_datapath_reset, .tx_reset_done, .rx_reset_done, .tx_xcvr_done, .tx_pll_reset,
  .rx_pll_reset, .tx_dp_reset, .common_reconfig_en, .core_clk_ratio, .usr_clk_ratio,
  .bytes_per_cycle);
`default_nettype wire

/* spc_xcvr_model.sv */
// Behavioural transceiver channel answering one direction's reset controls.
// Assumes the controls come from the wrapper on the same clock.
`default_nettype none
module spc_xcvr_model #(
  parameter int LOCK_DLY = 5,
  parameter int DONE_DLY = 3
) (
  // Clock
  input wire logic clk,
  // Controls from the wrapper
  input wire logic pll_reset,
  input wire logic dp_reset,
  // Status to the wrapper
  output logic pll_lock,
  output logic xcvr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int lock_cnt = 0;
  int done_cnt = 0;
  // Lock drops at once but returns only after settling
  always @(posedge clk) begin
    lock_cnt <= pll_reset ? 0 : (lock_cnt < LOCK_DLY ? lock_cnt + 1 : lock_cnt);
    done_cnt <= (dp_reset || !pll_lock) ? 0 : (done_cnt < DONE_DLY ? done_cnt + 1 : done_cnt);
  end
  assign pll_lock = lock_cnt == LOCK_DLY;
  assign xcvr_done = done_cnt == DONE_DLY;
endmodule : spc_xcvr_model
`default_nettype wire

/* spc_phy_top_test.sv */
// Self-checking bench for the serdes PHY wrapper: registers, bridge, resets.
// Assumes two channel models answer the resets; no quad PLL is selected.
`default_nettype none
`include "spc_defs.svh"
module spc_phy_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PLL_H = 4;
  localparam int DP_H = 2;
  logic core_clk;
  logic reset_n = 0;
  logic drp_en = 0;
  logic drp_we = 0;
  logic [8:0] drp_addr = 0;
  logic [15:0] drp_di = 0;
  logic mgmt_req_tgl = 0;
  logic mgmt_we = 0;
  logic [9:0] mgmt_addr = 0;
  logic [15:0] mgmt_wdata = 0;
  logic [3:0] rq = 0;
  logic [4:0] dbg = 0;
  wire logic [4:0] xcvr;
  wire logic core_clk_via_buffer;
  wire logic [1:0] refclk_used;
  wire logic [15:0] drp_do, mgmt_rdata;
  wire logic drp_rdy, mgmt_ack_tgl, tx_reset_done, rx_reset_done, tx_pll_lock, rx_pll_lock;
  wire logic tx_xcvr_done, rx_xcvr_done, tx_pll_reset, rx_pll_reset, tx_dp_reset, rx_dp_reset;
  wire logic [23:0] channel_pll_config;
  wire logic [2:0] channel_pll_ref_divider, channel_pll_fb_div_n1, channel_pll_fb_div_n2;
  wire logic channel_pll_div_invalid;
  wire logic [1:0] dn = {rx_reset_done, tx_reset_done};
  wire logic [1:0] plr = {rx_pll_reset, tx_pll_reset};
  int fail_count = 0;
  int comparisons = 0;

  spc_phy_top #(.QUAD_PLL_SELECTED(1'b0), .PLL_HOLD(PLL_H), .DP_HOLD(DP_H)) u_spc_phy_top (
    .core_clk, .reset_n, .drp_en, .drp_we, .drp_addr, .drp_di, .drp_do, .drp_rdy,
    .mgmt_req_tgl, .mgmt_we, .mgmt_addr, .mgmt_wdata, .mgmt_ack_tgl, .mgmt_rdata,
    .common_reconfig_en(), .common_reconfig_we(), .common_reconfig_addr(),
    .common_reconfig_di(), .common_reconfig_do(16'h0000), .common_reconfig_rdy(1'b0),
    .tx_sys_reset(rq[0]), .transmit_datapath_reset(rq[1]), .rx_sys_reset(rq[2]),
    .receive_datapath_reset(rq[3]), .tx_reset_done, .rx_reset_done,
    .tx_pll_lock, .rx_pll_lock, .tx_xcvr_done, .rx_xcvr_done,
    .tx_pll_reset, .rx_pll_reset, .tx_dp_reset, .rx_dp_reset,
    .channel_pll_config, .channel_pll_ref_divider, .channel_pll_fb_div_n1,
    .channel_pll_fb_div_n2, .channel_pll_div_invalid,
    .dbg_loopback(dbg[2:0]), .dbg_tx_polarity(dbg[3]), .dbg_rx_polarity(dbg[4]),
    .xcvr_loopback(xcvr[2:0]), .xcvr_tx_polarity(xcvr[3]), .xcvr_rx_polarity(xcvr[4]),
    .core_clk_ratio(), .usr_clk_ratio(), .core_clk_via_buffer, .bytes_per_cycle(),
    .refclk_used
  );
  // Receive channel deliberately slow to lock
  spc_xcvr_model #(.LOCK_DLY(3)) u_tx_chan (.clk(core_clk), .pll_reset(tx_pll_reset),
    .dp_reset(tx_dp_reset), .pll_lock(tx_pll_lock), .xcvr_done(tx_xcvr_done));
  spc_xcvr_model #(.LOCK_DLY(12)) u_rx_chan (.clk(core_clk), .pll_reset(rx_pll_reset),
    .dp_reset(rx_dp_reset), .pll_lock(rx_pll_lock), .xcvr_done(rx_xcvr_done));

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic dynamic_reconfig_port(input logic we, input logic [8:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge core_clk);
    drp_en = 1;
    drp_we = we;
    drp_addr = a;
    drp_di = d;
    @(negedge core_clk);
    cmp(drp_rdy, 1, "ready");
    q = drp_do;
    drp_en = 0;
  endtask : dynamic_reconfig_port

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] q;
    dynamic_reconfig_port(0, a, 0, q);
    cmp(q, exp, "read");
  endtask : rd

  // Debug inputs must lose to the control register while the bus is built in
  task automatic t_ctrl;
    logic [15:0] q;
    dbg = 5'h1F;
    dynamic_reconfig_port(1, `SPC_ADDR_CTRL, 16'h0015, q);
    rd(`SPC_ADDR_CTRL, 16'h0015);
    cmp(xcvr, 5'h15, "debug masked");
    cmp({core_clk_via_buffer, refclk_used}, 3'b001, "clocking");
    dynamic_reconfig_port(1, `SPC_ADDR_CTRL, 16'h0000, q);
    dbg = 5'h00;
  endtask : t_ctrl

  task automatic t_regs;
    logic [15:0] q;
    rd(`SPC_ADDR_CFG_LOW, 16'h0000);
    rd(`SPC_ADDR_DIV_SEL, 16'h1082);
    dynamic_reconfig_port(1, 9'h070, 16'hFFFF, q);
    rd(9'h070, 16'h0000);
    dynamic_reconfig_port(1, `SPC_ADDR_CFG_LOW, 16'hA5FF, q);
    dynamic_reconfig_port(1, `SPC_ADDR_CFG_HIGH, 16'h3C96, q);
    rd(`SPC_ADDR_CFG_LOW, 16'hA500);
    rd(`SPC_ADDR_CFG_HIGH, 16'h3C96);
    cmp(channel_pll_config, 24'h3C96A5, "config out");
  endtask : t_regs

  task automatic t_div;
    logic [15:0] q;
    logic [15:0] w;
    for (int i = 0; i < 5; i++) begin
      dynamic_reconfig_port(0, `SPC_ADDR_DIV_SEL, 0, q);
      w = q;
      w[12:8] = i[0] ? `SPC_ENC_M2 : `SPC_ENC_M1;
      w[7] = i[1];
      w[6:0] = (i == 0) ? `SPC_ENC_N2_1 : 7'(i - 1);
      dynamic_reconfig_port(1, `SPC_ADDR_DIV_SEL, w, q);
      rd(`SPC_ADDR_DIV_SEL, {3'h0, w[12:0]});
      cmp({channel_pll_div_invalid, channel_pll_ref_divider, channel_pll_fb_div_n1,
           channel_pll_fb_div_n2}, {1'b0, 3'(i[0] + 1), 3'(4 + i[1]), 3'(i + 1)}, "dec");
    end
    dynamic_reconfig_port(1, `SPC_ADDR_DIV_SEL, 16'h0182, q);
    rd(`SPC_ADDR_DIV_SEL, 16'h0182);
    cmp(channel_pll_div_invalid, 1, "bad code flagged");
    dynamic_reconfig_port(1, `SPC_ADDR_DIV_SEL, 16'h1082, q);
  endtask : t_div

  task automatic mgmt(input logic we, input logic [9:0] a, input logic [15:0] d,
                      input logic [15:0] exp);
    logic ack0;
    int n;
    ack0 = mgmt_ack_tgl;
    n = 0;
    @(negedge core_clk);
    mgmt_we = we;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_req_tgl = !mgmt_req_tgl;
    while (mgmt_ack_tgl === ack0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    cmp(n < 50, 1, "bridge ack");
    if (!we) cmp(mgmt_rdata, exp, "bridge data");
  endtask : mgmt

  task automatic t_rst(input logic rx, input logic sys);
    int n;
    n = 0;
    @(negedge core_clk);
    rq[{rx, !sys}] = 1;
    repeat (10) @(negedge core_clk);
    cmp(dn, rx ? 2'b01 : 2'b10, "done flags");
    cmp(plr[rx], sys, "pll reset");
    rq[{rx, !sys}] = 0;
    while (dn[rx] !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    cmp(n > (sys ? PLL_H : DP_H) && n < 200, 1, "done return");
  endtask : t_rst

  task automatic end_of_test;
    $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    int n;
    n = 0;
    repeat (4) @(negedge core_clk);
    reset_n = 1;
    while (dn !== 2'b11 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    cmp(dn, 2'b11, "startup done");
    t_regs;
    t_div;
    t_ctrl;
    mgmt(0, {1'b0, `SPC_ADDR_DIV_SEL}, 0, 16'h1082);
    mgmt(1, {1'b0, `SPC_ADDR_CFG_HIGH}, 16'h0F0F, 0);
    rd(`SPC_ADDR_CFG_HIGH, 16'h0F0F);
    mgmt(0, {1'b1, `SPC_ADDR_DIV_SEL}, 0, 16'h0000);
    for (int k = 0; k < 4; k++) t_rst(k[1], k[0]);
    end_of_test;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #300000;
    fail_count++;
    end_of_test;
  end
endmodule : spc_phy_top_test
`default_nettype wire
